// File: shared/lcu_pkg.sv
`default_nettype none
package lcu_pkg;

	// command codes written with a0 high
	localparam logic [7:0] CMD_MEM_WRITE     = 8'h42;
	localparam logic [7:0] CMD_MEM_READ      = 8'h43;
	localparam logic [7:0] CMD_CURSOR_WRITE  = 8'h46;
	localparam logic [7:0] CMD_CURSOR_READ   = 8'h47;
	localparam logic [7:0] CMD_DIR_BASE      = 8'h4c; // 4c..4f, low two bits pick the direction
	localparam logic [7:0] CMD_PIXEL_SCROLL  = 8'h5a;
	localparam logic [7:0] CMD_LAYER_SETUP   = 8'h5b;
	localparam logic [7:0] CMD_CHARGEN_ADDR  = 8'h5c;

	// layer setup parameter field positions
	localparam int LAYER_BIT   = 4;
	localparam int DM_B3_BIT   = 3;
	localparam int DM_B1_BIT   = 2;
	// pixel scroll shift width
	localparam int SHIFT_W     = 3;
	// status byte: busy flag position
	localparam int STAT_BUSY_BIT = 7;

	// reset values
	localparam logic [15:0] CURSOR_RESET  = 16'h0000;
	localparam logic [15:0] CHARGEN_RESET = 16'h0000;
	localparam logic [2:0]  SHIFT_RESET   = 3'h0;

	// auto-increment direction, codes equal the command's low bits
	typedef enum logic [1:0] {
		DIR_RIGHT = 2'b00,
		DIR_LEFT  = 2'b01,
		DIR_UP    = 2'b10,
		DIR_DOWN  = 2'b11
	} lcu_dir_t;

	// command unit states, gray along idle -> param and idle -> fetch -> read stream paths
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_PARAM   = 3'b001,
		ST_WSTREAM = 3'b011,
		ST_RFETCH  = 3'b010,
		ST_RSTREAM = 3'b110,
		ST_CREAD   = 3'b111
	} lcu_state_t;

	// host pins sampled as synchronous inputs
	typedef struct packed {
		logic       cs_n;
		logic       rd_n;
		logic       wr_n;
		logic       a0;
		logic [7:0] data;
	} lcu_host_t;

	// settings held for the display side
	typedef struct packed {
		logic           block1_display_mode;
		logic           block3_display_mode;
		logic           layer_count_select;
		logic [15:0]    chargen_start;
		logic [SHIFT_W-1:0] pixel_shift;
	} lcu_cfg_t;

	// one queued display memory write
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data;
	} lcu_mem_wr_t;

endpackage : lcu_pkg
`default_nettype wire

// File: design/lcu_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module lcu_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	// clocking
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	input  wire logic             ce,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	// pointers carry one extra wrap bit for honest full/empty
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} lcu_fifo_regs_t;

	lcu_fifo_regs_t           q;    // registered pointers
	lcu_fifo_regs_t           d;    // next pointers
	logic [WIDTH-1:0]         store [DEPTH]; // word storage
	logic                     push; // accepted write
	logic                     pop;  // accepted read

	// full when pointers differ only in the wrap bit
	assign in_ready  = !((q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]));
	assign out_valid = (q.wp != q.rp);
	assign out_data  = store[q.rp[AW-1:0]];
	assign push      = ce && in_valid && in_ready;
	assign pop       = ce && out_valid && out_ready;

	// pointer advance
	always_comb begin
		d = q;
		if (push) begin
			d.wp = q.wp + 1'b1;
		end
		if (pop) begin
			d.rp = q.rp + 1'b1;
		end
	end

	// pointer registers, synchronous reset
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// storage needs no reset, empty flag guards stale words
	always_ff @(posedge sys_clk) begin
		if (push) begin
			store[q.wp[AW-1:0]] <= in_data;
		end
	end

endmodule : lcu_fifo
`default_nettype wire

// File: design/lcu_disp_mem.sv
`timescale 1ns/1ps
`default_nettype none
module lcu_disp_mem #(
	parameter int AW = 16
) (
	// clocking
	input  wire logic          sys_clk,
	input  wire logic          ce,
	// write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [7:0]    wdata,
	// read port, one cycle latency
	input  wire logic          re,
	input  wire logic [AW-1:0] raddr,
	output logic [7:0]         rdata
);
	logic [7:0] cells [2**AW]; // display memory bytes

	// byte array with registered read
	always_ff @(posedge sys_clk) begin
		if (ce && we) begin
			cells[waddr] <= wdata;
		end
		if (ce && re) begin
			rdata <= cells[raddr];
		end
	end

endmodule : lcu_disp_mem
`default_nettype wire

// File: design/lcu_cmd_unit.sv
`timescale 1ns/1ps
`default_nettype none
module lcu_cmd_unit
	import lcu_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	// clocking
	input  wire logic              sys_clk,
	input  wire logic              reset_n,
	input  wire logic              ce,
	// host parallel bus
	input  wire lcu_host_t         host,
	output logic [7:0]             db_out,
	output logic                   db_oe,
	// display side inputs
	input  wire logic [15:0]       address_pitch,
	input  wire logic              cursor_shown,
	input  wire logic              display_fetch,
	// display side settings
	output lcu_cfg_t               cfg,
	output logic [3:0]             block_graphics,
	output logic                   three_layer,
	// status
	output logic                   busy
);

	// whole register state of the command unit
	typedef struct packed {
		lcu_state_t  st;        // sequencing state
		logic [7:0]  cmd;       // command owning the parameters
		logic        pidx;      // parameter byte index
		logic [15:0] cursor;    // cursor address register
		lcu_dir_t    dir;       // auto-increment direction
		lcu_cfg_t    cfg;       // display settings
		logic [7:0]  rbuf;      // memory read buffer
		logic        fetch_wait; // read issued, data next cycle
		logic [7:0]  dout;      // byte presented to the host
		logic        wr_prev;   // write strobe seen last cycle
		logic        rd_prev;   // read strobe seen last cycle
	} lcu_regs_t;

	lcu_regs_t    q;            // registered state
	lcu_regs_t    d;            // next state

	// strobes and decode
	logic         wr_act;       // host write strobe active
	logic         rd_act;       // host read strobe active
	logic         wr_pulse;     // first cycle of a write
	logic         rd_pulse;     // first cycle of a read

	// fifo fill side
	logic         push_valid;   // queue a memory write
	logic         push_ready;   // queue has room
	lcu_mem_wr_t  push_word;    // address and data queued

	// fifo drain side
	logic         pop_valid;    // queued write waiting
	logic         pop_ready;    // memory free this cycle
	lcu_mem_wr_t  pop_word;     // write leaving the queue

	// memory read port
	logic         mem_re;       // fetch request
	logic [15:0]  mem_raddr;    // fetch address
	logic [7:0]   mem_rdata;    // fetched byte
	logic [15:0]  fetch_addr;   // address for next buffer fill

	// one auto-increment step of the cursor
	function automatic logic [15:0] step_addr(input logic [15:0] a, input lcu_dir_t dr,
			input logic [15:0] pitch);
		logic [15:0] r;
		r = a;
		unique case (dr)
			DIR_RIGHT: r = a + 16'h0001;
			DIR_LEFT:  r = a - 16'h0001;
			DIR_UP:    r = a - pitch;
			DIR_DOWN:  r = a + pitch;
		endcase
		return r;
	endfunction : step_addr

	// true for the four direction command codes
	function automatic logic is_dir_cmd(input logic [7:0] c);
		return (c[7:2] == CMD_DIR_BASE[7:2]);
	endfunction : is_dir_cmd

	// strobes are level inputs; act once on their leading cycle
	assign wr_act   = !host.cs_n && !host.wr_n;
	assign rd_act   = !host.cs_n && !host.rd_n;
	assign wr_pulse = wr_act && !q.wr_prev;
	assign rd_pulse = rd_act && !q.rd_prev;

	// bus drive while the host reads, data itself is a flop
	assign db_oe  = rd_act;
	assign db_out = q.dout;

	// settings go out straight from flops
	assign cfg = q.cfg;
	// blocks 1 and 3 follow their bits, 2 and 4 are fixed graphics
	assign block_graphics = {1'b1, q.cfg.block3_display_mode,
	                         1'b1, q.cfg.block1_display_mode};
	// a third layer only exists when the first layer is graphics
	assign three_layer = q.cfg.layer_count_select && q.cfg.block1_display_mode;

	// host must hold off while the queue is full or a fetch is pending
	assign busy = !push_ready || (q.st == ST_RFETCH);

	// the shown cursor sits two steps behind the read pointer
	assign fetch_addr = cursor_shown
	                  ? step_addr(step_addr(q.cursor, q.dir, address_pitch), q.dir, address_pitch)
	                  : q.cursor;

	// memory is stolen by display refresh in fetch cycles
	assign pop_ready = !display_fetch;

	// next-state logic
	always_comb begin
		d          = q;
		push_valid = 1'b0;
		push_word  = '{addr: q.cursor, data: host.data};
		mem_re     = 1'b0;
		mem_raddr  = fetch_addr;
		d.wr_prev  = wr_act;
		d.rd_prev  = rd_act;

		// fetched byte lands one cycle after the request
		if (q.fetch_wait) begin
			d.fetch_wait = 1'b0;
			d.rbuf       = mem_rdata;
			if (q.st == ST_RFETCH) begin
				d.st = ST_RSTREAM;
			end
		end

		// fetch waits for queued writes so reads see them
		if (q.st == ST_RFETCH && !q.fetch_wait && !pop_valid && !display_fetch) begin
			mem_re       = 1'b1;
			d.fetch_wait = 1'b1;
		end

		if (wr_pulse && host.a0) begin
			// a command byte ends any stream in flight
			d.cmd        = host.data;
			d.pidx       = 1'b0;
			d.st         = ST_IDLE;
			d.fetch_wait = 1'b0;
			if (is_dir_cmd(host.data)) begin
				d.dir = lcu_dir_t'(host.data[1:0]);
			end else begin
				unique case (host.data)
					CMD_CURSOR_WRITE: d.st = ST_PARAM;
					CMD_CURSOR_READ:  d.st = ST_CREAD;
					CMD_MEM_WRITE:    d.st = ST_WSTREAM;
					CMD_MEM_READ:     d.st = ST_RFETCH;
					CMD_PIXEL_SCROLL: d.st = ST_PARAM;
					CMD_LAYER_SETUP:  d.st = ST_PARAM;
					CMD_CHARGEN_ADDR: d.st = ST_PARAM;
					default:          d.st = ST_IDLE;
				endcase
			end
		end else if (wr_pulse) begin
			// parameter or stream data byte
			unique case (q.st)
				ST_PARAM: begin
					unique case (q.cmd)
						CMD_CURSOR_WRITE: begin
							// low byte first, high byte closes the load
							if (!q.pidx) begin
								d.cursor[7:0] = host.data;
								d.pidx        = 1'b1;
							end else begin
								d.cursor[15:8] = host.data;
								d.st           = ST_IDLE;
							end
						end
						CMD_CHARGEN_ADDR: begin
							// second byte carries the upper address bits
							if (!q.pidx) begin
								d.cfg.chargen_start[7:0] = host.data;
								d.pidx                   = 1'b1;
							end else begin
								d.cfg.chargen_start[15:8] = host.data;
								d.st                      = ST_IDLE;
							end
						end
						CMD_PIXEL_SCROLL: begin
							// upper bits are zero by definition and ignored
							d.cfg.pixel_shift = host.data[SHIFT_W-1:0];
							d.st              = ST_IDLE;
						end
						CMD_LAYER_SETUP: begin
							d.cfg.layer_count_select  = host.data[LAYER_BIT];
							d.cfg.block3_display_mode = host.data[DM_B3_BIT];
							d.cfg.block1_display_mode = host.data[DM_B1_BIT];
							d.st                      = ST_IDLE;
						end
						default: d.st = ST_IDLE;
					endcase
				end
				ST_WSTREAM: begin
					// a byte offered while full is lost; host watches busy
					push_valid = 1'b1;
					if (push_ready) begin
						d.cursor = step_addr(q.cursor, q.dir, address_pitch);
					end
				end
				default: begin
					// stray data bytes are ignored
					d.st = q.st;
				end
			endcase
		end

		if (rd_pulse && host.a0) begin
			unique case (q.st)
				ST_CREAD: begin
					// two reads give the low then the high byte
					if (!q.pidx) begin
						d.dout = q.cursor[7:0];
						d.pidx = 1'b1;
					end else begin
						d.dout = q.cursor[15:8];
						d.st   = ST_IDLE;
					end
				end
				ST_RSTREAM: begin
					// hand out the buffer, step, refill
					d.dout   = q.rbuf;
					d.cursor = step_addr(q.cursor, q.dir, address_pitch);
					d.st     = ST_RFETCH;
				end
				default: begin
					// early reads return the last byte again
					d.dout = q.dout;
				end
			endcase
		end else if (rd_pulse) begin
			// status read
			d.dout                = 8'h00;
			d.dout[STAT_BUSY_BIT] = busy;
		end
	end

	// state register with clock enable
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			q                         <= '0;
			q.st                      <= ST_IDLE;
			q.dir                     <= DIR_RIGHT;
			q.cursor                  <= CURSOR_RESET;
			q.cfg.chargen_start       <= CHARGEN_RESET;
			q.cfg.pixel_shift         <= SHIFT_RESET;
			q.wr_prev                 <= 1'b1;
			q.rd_prev                 <= 1'b1;
		end else if (ce) begin
			q <= d;
		end
	end

	// queued writes decouple host pace from memory slots
	lcu_fifo #(
		.WIDTH ($bits(lcu_mem_wr_t)),
		.DEPTH (FIFO_DEPTH)
	) u_wr_fifo (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.ce        (ce),
		.in_valid  (push_valid && ce),
		.in_ready  (push_ready),
		.in_data   (push_word),
		.out_valid (pop_valid),
		.out_ready (pop_ready),
		.out_data  (pop_word)
	);

	// display memory, only this unit writes or reads it
	lcu_disp_mem #(
		.AW (16)
	) u_mem (
		.sys_clk (sys_clk),
		.ce      (ce),
		.we      (pop_valid && pop_ready),
		.waddr   (pop_word.addr),
		.wdata   (pop_word.data),
		.re      (mem_re),
		.raddr   (mem_raddr),
		.rdata   (mem_rdata)
	);

endmodule : lcu_cmd_unit
`default_nettype wire

// File: tb/lcu_cmd_sva.sv
`timescale 1ns/1ps
`default_nettype none
module lcu_cmd_sva
	import lcu_pkg::*;
(
	// clocking
	input wire logic       sys_clk,
	input wire logic       reset_n,
	// host side
	input wire lcu_host_t  host,
	input wire logic [7:0] db_out,
	input wire logic       db_oe,
	// display settings
	input wire lcu_cfg_t   cfg,
	input wire logic [3:0] block_graphics,
	input wire logic       three_layer
);
	// one clock domain, one reset
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	// parameter byte being written
	logic pw;
	// read strobe active on a selected bus
	logic rs;
	assign pw = !host.cs_n && !host.wr_n && !host.a0;
	assign rs = !host.cs_n && !host.rd_n;

	a_even_blocks: assert property (block_graphics[1] && block_graphics[3])
		else $error("even blocks not graphics");
	a_block_modes: assert property (block_graphics[0] == cfg.block1_display_mode &&
		block_graphics[2] == cfg.block3_display_mode)
		else $error("block mode bits not passed on");
	a_layer_count: assert property (three_layer == (cfg.layer_count_select && cfg.block1_display_mode))
		else $error("layer count wrong");
	a_read_enable: assert property (db_oe == rs)
		else $error("read enable wrong");
	a_dout_by_read: assert property ($changed(db_out) |-> $past(rs) || $past(rs, 2))
		else $error("read data moved without a read");
	a_shift_by_param: assert property ($changed(cfg.pixel_shift) |-> $past(pw) || $past(pw, 2))
		else $error("shift moved without a parameter");
	a_chargen_by_param: assert property ($changed(cfg.chargen_start) |-> $past(pw) || $past(pw, 2))
		else $error("chargen start moved without a parameter");
	a_mode_by_param: assert property ($changed({cfg.block1_display_mode, cfg.block3_display_mode,
		cfg.layer_count_select}) |-> $past(pw) || $past(pw, 2))
		else $error("mode bits moved without a parameter");
endmodule : lcu_cmd_sva
`default_nettype wire

// File: tb/lcu_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcu_host_model
	import lcu_pkg::*;
(
	// clocking
	input wire logic       sys_clk,
	// bus toward the block
	output lcu_host_t      host,
	input wire logic [7:0] db_out
);
	// idle bus: chip deselected, strobes high
	initial host = 12'hf00;

	// one write: strobe low two edges, then high one edge
	task wr(input logic a0, input logic [7:0] d);
		@(posedge sys_clk);
		host <= {3'b010, a0, d};
		repeat (2) @(posedge sys_clk);
		// released data lines show the inverse, never a stale copy
		host <= {3'b111, a0, ~d};
		@(posedge sys_clk);
	endtask : wr

	// one read: data sampled while the strobe is still held
	task rd(input logic a0, output logic [7:0] d);
		@(posedge sys_clk);
		host <= {3'b001, a0, host.data};
		repeat (3) @(posedge sys_clk);
		d = db_out;
		host <= {3'b111, a0, ~host.data};
		@(posedge sys_clk);
	endtask : rd
endmodule : lcu_host_model
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
	$display("wrong value %s expected %h seen %h", n, e, g); end end
module tb
	import lcu_pkg::*;
;
	localparam int FD = 16; // fifo depth
	// clock, reset and display side inputs
	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        cursor_shown = 1'b0;
	logic        display_fetch = 1'b0;
	logic [15:0] address_pitch = 16'h0028;
	// design outputs
	lcu_host_t   host;
	logic [7:0]  db_out;
	logic        db_oe;
	lcu_cfg_t    cfg;
	logic [3:0]  block_graphics;
	logic        three_layer;
	logic        busy;
	int          fails = 0;
	int          checked = 0;

	// 25 MHz
	always #20 sys_clk = ~sys_clk;

	lcu_cmd_unit #(.FIFO_DEPTH(FD)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .ce(1'b1), .host(host),
		.db_out(db_out), .db_oe(db_oe), .address_pitch(address_pitch), .cursor_shown(cursor_shown),
		.display_fetch(display_fetch), .cfg(cfg), .block_graphics(block_graphics),
		.three_layer(three_layer), .busy(busy));
	lcu_host_model i_host (.sys_clk(sys_clk), .host(host), .db_out(db_out));

	task results;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results

	// bus shorthands
	task cmd(input logic [7:0] c);
		i_host.wr(1'b1, c);
	endtask : cmd
	task par(input logic [7:0] p);
		i_host.wr(1'b0, p);
	endtask : par
	task curs(input logic [15:0] a);
		cmd(CMD_CURSOR_WRITE);
		par(a[7:0]);
		par(a[15:8]);
	endtask : curs
	task cur_chk(input logic [15:0] e);
		logic [7:0] lo, hi;
		cmd(CMD_CURSOR_READ);
		i_host.rd(1'b1, lo);
		i_host.rd(1'b1, hi);
		`CHK("cursor", e, {hi, lo})
	endtask : cur_chk
	// status poll, bounded; a hang ends the run
	task poll;
		logic [7:0] s;
		s = 8'hff;
		for (int n = 0; n < 60 && s[STAT_BUSY_BIT] !== 1'b0; n++)
			i_host.rd(1'b0, s);
		if (s[STAT_BUSY_BIT] !== 1'b0) begin
			fails++;
			$display("wrong value busy expected 0 seen %b", s[STAT_BUSY_BIT]);
			results;
		end
	endtask : poll

	task t_reset;
		`CHK("cfg", '0, cfg)
		`CHK("graphics", 4'ha, block_graphics)
		`CHK("layers", 1'b0, three_layer)
		`CHK("busy", 1'b0, busy)
	endtask : t_reset

	// mode bits kept equal, layer bit clear with text
	task t_layer;
		logic [7:0] v [3] = '{8'h00, 8'h1c, 8'h0c};
		for (int k = 0; k < 3; k++) begin
			cmd(CMD_LAYER_SETUP);
			par(v[k]);
			`CHK("graphics", {1'b1, v[k][DM_B3_BIT], 1'b1, v[k][DM_B1_BIT]}, block_graphics)
			`CHK("layers", v[k][LAYER_BIT], three_layer)
		end
	endtask : t_layer

	task t_scroll;
		curs(16'h0abc);
		cmd(CMD_PIXEL_SCROLL);
		par(8'h07);
		`CHK("shift", 3'h7, cfg.pixel_shift)
		cmd(CMD_PIXEL_SCROLL);
		par(8'h05);
		`CHK("shift", 3'h5, cfg.pixel_shift)
		cur_chk(16'h0abc);
		cmd(CMD_CHARGEN_ADDR);
		par(8'h34);
		par(8'h12);
		`CHK("chargen", 16'h1234, cfg.chargen_start)
	endtask : t_scroll

	task t_stream;
		logic [7:0] d;
		cmd(CMD_DIR_BASE);
		curs(16'h0010);
		cmd(CMD_MEM_WRITE);
		for (int k = 1; k < 4; k++) begin
			poll;
			par(8'h11 * k[7:0]);
		end
		cur_chk(16'h0013);
		curs(16'h0010);
		cmd(CMD_MEM_READ);
		for (int k = 1; k < 4; k++) begin
			poll;
			i_host.rd(1'b1, d);
			`CHK("read", 8'h11 * k[7:0], d)
		end
		@(posedge sys_clk) cursor_shown <= 1'b1;
		curs(16'h0010);
		cmd(CMD_MEM_READ);
		poll;
		i_host.rd(1'b1, d);
		`CHK("read ahead", 8'h33, d)
		@(posedge sys_clk) cursor_shown <= 1'b0;
		cmd(CMD_DIR_BASE);
		par(8'h99);
		cur_chk(16'h0011);
	endtask : t_stream

	// right, left, up, down: two writes each
	task t_dirs;
		logic [15:0] st [4] = '{16'h0000, 16'h0020, 16'h0100, 16'h0100};
		logic [15:0] ex [4] = '{16'h0002, 16'h001e, 16'h00b0, 16'h0150};
		for (int k = 0; k < 4; k++) begin
			cmd(CMD_DIR_BASE + k[7:0]);
			curs(st[k]);
			cmd(CMD_MEM_WRITE);
			repeat (2) begin
				poll;
				par(8'h5a);
			end
			cur_chk(ex[k]);
		end
	endtask : t_dirs

	// memory side stalled: fill past full, then drain
	task t_fifo;
		logic [7:0] d;
		@(posedge sys_clk) display_fetch <= 1'b1;
		cmd(CMD_DIR_BASE);
		curs(16'h0200);
		cmd(CMD_MEM_WRITE);
		repeat (FD + 1) par(8'h77);
		`CHK("busy", 1'b1, busy)
		@(posedge sys_clk) display_fetch <= 1'b0;
		poll;
		cur_chk(16'h0200 + 16'(FD));
		curs(16'h0200 + 16'(FD - 1));
		cmd(CMD_MEM_READ);
		poll;
		i_host.rd(1'b1, d);
		`CHK("drained", 8'h77, d)
	endtask : t_fifo

	initial begin
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		t_reset;
		t_layer;
		t_scroll;
		t_stream;
		t_dirs;
		t_fifo;
		results;
	end
endmodule : tb

bind lcu_cmd_unit lcu_cmd_sva i_sva (.sys_clk(sys_clk), .reset_n(reset_n), .host(host), .db_out(db_out),
	.db_oe(db_oe), .cfg(cfg), .block_graphics(block_graphics), .three_layer(three_layer));
`default_nettype wire
